// >>> rsoc_cfg.svh
// Purpose: constants of the RTC housekeeping block
// Assumes: 25 MHz system clock, APB word addressing
// Notes:   register index times four is the byte address
`ifndef RSOC_CFG_SVH
`define RSOC_CFG_SVH
// ----------------------------------------
// Register indices
// ----------------------------------------
`define RSOC_IX_HALT 5'h01
`define RSOC_IX_CENT 5'h06
`define RSOC_IX_CTRL 5'h08
`define RSOC_IX_WDOG 5'h09
`define RSOC_IX_ALM1 5'h0A
`define RSOC_IX_OSC_FAIL_IRQ_EN 5'h0B
`define RSOC_IX_HTF  5'h0C
`define RSOC_IX_RPT1 5'h0D
`define RSOC_IX_ALM2 5'h0E
`define RSOC_IX_FLAG 5'h0F
`define RSOC_IX_TVAL 5'h10
`define RSOC_IX_TCTL 5'h11
`define RSOC_IX_ACAL 5'h12
`define RSOC_IX_SQW  5'h13
// ----------------------------------------
// Field positions
// ----------------------------------------
`define RSOC_B_TOP   7
`define RSOC_B_FT    6
`define RSOC_B_SQ_OUT_EN  6
`define RSOC_B_HT    6
`define RSOC_B_BL    4
`define RSOC_B_TF    3
`define RSOC_B_OF    2
`define RSOC_B_OTP   3
`define RSOC_B_TIE   5
`define RSOC_F_RATE  7:4
`define RSOC_F_CENT  7:6
`define RSOC_F_TRIG  6:0
`define RSOC_F_YLO   1:0
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define RSOC_RST_CTRL 8'h80
`define RSOC_RST_ALM1 8'h40
`define RSOC_RST_SQW  8'h10
`define RSOC_RST_TCTL 8'h03
`define RSOC_RATE_OFF 4'h0
`define RSOC_RATE_OSC 4'h1
`define RSOC_CENT_LEAP 2'h0
`define RSOC_Y_ZERO   7'h00
`define RSOC_Y_LO0    2'h0
// ----------------------------------------
// Timing
// ----------------------------------------
`define RSOC_CLK_MHZ  25
`define RSOC_TRIM_US  4000
`define RSOC_BATT_S   86400
`define RSOC_DIV_W    15
`endif

// >>> rsoc_pkg.sv
// Purpose: types of the RTC housekeeping block
// Assumes: nothing
// Notes:   constants live in rsoc_cfg.svh
package rsoc_pkg;
    typedef logic [7:0] rsoc_byte_t;
    typedef logic [4:0] rsoc_idx_t;
    typedef enum logic [1:0] {TRIM_IDLE, TRIM_WAIT, TRIM_DONE} rsoc_trim_e;
endpackage

// >>> rsoc_status_ctrl.sv
// Purpose: square wave, battery check, century, shared pin, osc fail,
//          power-on defaults and factory trim of a serial RTC
// Assumes: APB slave, one wait state; analog pins are synchronised
// Notes:   reset_n is the power-on reset; vccOk rise is a later power-up
// Operation
// - Rate field picks square-wave frequency
// - Square wave only while enable set
// - No square wave on battery
// - Battery check at power-up, daily
// - Low battery sets flag bit
// - Flag holds until a good check
// - Checks only with main supply
// - Two-bit century counter, 00 is leap
// - Leap years by 4, 100, 400
// - Unconfigured shared pin follows output bit
// - Timer value write keeps countdown flag
// - Oscillator stop sets fail flag
// - Fail flag with enable drives pin
// - Fail flag clears only by writing 0
// - Fail recorded even while powered down
// - Initial power-up clears and sets controls
// - Initial power-up flags and timer defaults
// - Later power-up clears few, sets HT flag, keeps rest
// - Trim select loads factory trim, read-only
// - Trim select low: plain storage
// - Trim load waits about 4 ms
// - Flags read clears countdown flag
`timescale 1ns/1ps
`include "rsoc_cfg.svh"
`default_nettype none
module rsoc_status_ctrl #(
    parameter int BATT_PERIOD_S = `RSOC_BATT_S,
    parameter int TRIM_CYCLES   = `RSOC_TRIM_US * `RSOC_CLK_MHZ
) (
    input  wire logic               clk,          // 25 MHz
    input  wire logic               reset_n,      // power-on reset
    input  wire logic [7:0]         paddr,        // byte address
    input  wire logic               psel,         // select
    input  wire logic               penable,      // access phase
    input  wire logic               pwrite,       // write
    input  wire logic [31:0]        pwdata,       // write data
    input  wire logic [3:0]         pstrb,        // byte strobes
    output logic [31:0]             prdata,       // read data
    output logic                    pready,       // ready
    output logic                    pslverr,      // unmapped
    input  wire logic               oscClkPin,    // 32.768 kHz
    input  wire logic               vccOkPin,     // main supply good
    input  wire logic               battLowPin,   // battery comparator
    input  wire logic               oscRunPin,    // osc detector
    input  wire logic               countdownDone, // timer end pulse
    input  wire logic               alarm1Hit,    // alarm 1 level
    input  wire logic               wdogExpired,  // watchdog level
    input  wire logic               centuryTick,  // year 99 to 00
    input  wire logic [6:0]         yearBin,      // year 0..99
    input  wire rsoc_pkg::rsoc_byte_t factoryTrim, // trim value
    output logic                    sqWavePin,    // square wave
    output logic                    sharedIrqOut, // pin level
    output logic                    sharedIrqOe,  // pin pulled low
    output logic                    leapYear,     // current year leap
    output logic                    oscHalt,      // halt oscillator
    output logic                    freqTestEn,   // freq test
    output logic                    countdownRunEn // timer enable
);
    import rsoc_pkg::*;
    // ----------------------------------------
    // Reset and pin synchronisers
    // ----------------------------------------
    logic [1:0] rstSync_q;
    logic       rstN;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) rstSync_q <= '0;
        else rstSync_q <= {rstSync_q[0], 1'b1};
    end
    assign rstN = rstSync_q[1];
    logic [3:0] pinMeta_q, pinSync_q;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pinMeta_q <= '0;
            pinSync_q <= '0;
        end else begin
            pinMeta_q <= {oscRunPin, battLowPin, vccOkPin, oscClkPin};
            pinSync_q <= pinMeta_q;
        end
    end
    logic oscS, vccS, battLowS, oscRunS;
    assign {oscRunS, battLowS, vccS, oscS} = pinSync_q;
    logic oscPrev_q, vccPrev_q, started_q;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            oscPrev_q <= 1'b0;
            vccPrev_q <= 1'b0;
            started_q <= 1'b0;
        end else begin
            oscPrev_q <= oscS;
            vccPrev_q <= vccS;
            started_q <= 1'b1;
        end
    end
    logic oscRise, vccRise, firstCyc;
    assign oscRise  = oscS & ~oscPrev_q;
    assign vccRise  = vccS & ~vccPrev_q;
    assign firstCyc = ~started_q;
    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    rsoc_idx_t idx;
    logic rdy_q, apbAcc, wrEn, rdDone;
    assign idx    = paddr[6:2];
    assign apbAcc = psel & penable;
    assign wrEn   = apbAcc & rdy_q & pwrite & pstrb[0];
    assign rdDone = apbAcc & rdy_q & ~pwrite;
    assign pready = rdy_q;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) rdy_q <= 1'b0;
        else rdy_q <= apbAcc & ~rdy_q;
    end
    logic [7:0] wb;
    assign wb = pwdata[7:0];
    function automatic logic wr(input rsoc_idx_t ix);
        wr = wrEn && (idx == ix);
    endfunction
    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    rsoc_byte_t ctrl_q, wdog_q, alm1_q, rpt1_q, alm2_q, tval_q, tctl_q, sqw_q;
    logic [1:0] cent_q;
    logic       osc_fail_irq_en_q;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ctrl_q  <= `RSOC_RST_CTRL;
            alm1_q  <= `RSOC_RST_ALM1;
            oscHalt <= 1'b0;
            osc_fail_irq_en_q  <= 1'b0;
        end else begin
            if (wr(`RSOC_IX_CTRL)) ctrl_q <= wb;
            else if (vccRise) ctrl_q[`RSOC_B_FT] <= 1'b0;
            if (wr(`RSOC_IX_ALM1)) alm1_q <= wb;
            if (wr(`RSOC_IX_HALT)) oscHalt <= wb[`RSOC_B_TOP];
            if (wr(`RSOC_IX_OSC_FAIL_IRQ_EN)) osc_fail_irq_en_q <= wb[`RSOC_B_TOP];
        end
    end
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            wdog_q <= '0;
            rpt1_q <= '0;
            alm2_q <= '0;
            tval_q <= '0;
            tctl_q <= `RSOC_RST_TCTL;
            sqw_q  <= `RSOC_RST_SQW;
        end else begin
            if (wr(`RSOC_IX_WDOG)) wdog_q <= wb;
            else if (vccRise) wdog_q <= '0;
            if (wr(`RSOC_IX_TCTL)) tctl_q <= wb;
            else if (vccRise) tctl_q[`RSOC_B_TOP] <= 1'b0;
            if (wr(`RSOC_IX_RPT1)) rpt1_q <= wb;
            if (wr(`RSOC_IX_ALM2)) alm2_q <= wb;
            if (wr(`RSOC_IX_TVAL)) tval_q <= wb;
            if (wr(`RSOC_IX_SQW)) sqw_q <= wb;
        end
    end
    assign freqTestEn     = ctrl_q[`RSOC_B_FT];
    assign countdownRunEn = tctl_q[`RSOC_B_TOP];
    // ----------------------------------------
    // Century and leap year
    // ----------------------------------------
    // binary century count
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) cent_q <= '0;
        else if (centuryTick) cent_q <= cent_q + 2'h1;
        else if (wr(`RSOC_IX_CENT)) cent_q <= wb[`RSOC_F_CENT];
    end
    // year 00 is leap only in century 00
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) leapYear <= 1'b0;
        else leapYear <= (yearBin[`RSOC_F_YLO] == `RSOC_Y_LO0) &&
            ((yearBin != `RSOC_Y_ZERO) || (cent_q == `RSOC_CENT_LEAP));
    end
    // ----------------------------------------
    // Oscillator divider and square wave
    // ----------------------------------------
    logic [`RSOC_DIV_W-1:0] div_q;
    // binary ripple of osc edges, 50 percent duty
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) div_q <= '0;
        else if (oscRise) div_q <= div_q + 1'b1;
    end
    logic secTick, sqSel;
    assign secTick = oscRise & (&div_q);
    logic [3:0] rate;
    assign rate = sqw_q[`RSOC_F_RATE];
    // code 1 is the raw osc, code n is osc over 2^n
    always_comb begin
        sqSel = 1'b0;
        if (rate == `RSOC_RATE_OSC) sqSel = oscS;
        else if (rate != `RSOC_RATE_OFF) sqSel = div_q[rate - 4'h1];
    end
    // gated by enable and main supply
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) sqWavePin <= 1'b0;
        else sqWavePin <= sqSel & alm1_q[`RSOC_B_SQ_OUT_EN] & vccS;
    end
    // ----------------------------------------
    // Battery monitor
    // ----------------------------------------
    logic [16:0] secCnt_q;
    logic battLow_q, battCheck;
    // at power-up and each period, main supply only
    assign battCheck = vccS & (firstCyc | vccRise |
        (secTick & (secCnt_q == 17'(BATT_PERIOD_S - 1))));
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) secCnt_q <= '0;
        else if (!vccS || battCheck) secCnt_q <= '0;
        else if (secTick) secCnt_q <= secCnt_q + 17'h1;
    end
    // flag follows only the latest check
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) battLow_q <= 1'b0;
        else if (battCheck) battLow_q <= battLowS;
    end
    // ----------------------------------------
    // Flags: osc fail, countdown, halt update
    // ----------------------------------------
    logic oscFail_q, cdFlag_q, htf_q, oscStopped;
    assign oscStopped = ~oscRunS | oscHalt;
    // set wins, clear by writing 0
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) oscFail_q <= 1'b1;
        else if (oscStopped) oscFail_q <= 1'b1;
        else if (wr(`RSOC_IX_FLAG) && !wb[`RSOC_B_OF]) oscFail_q <= 1'b0;
    end
    // only a flags read clears it
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) cdFlag_q <= 1'b0;
        else if (countdownDone) cdFlag_q <= 1'b1;
        else if (rdDone && idx == `RSOC_IX_FLAG) cdFlag_q <= 1'b0;
    end
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) htf_q <= 1'b1;
        else if (vccRise) htf_q <= 1'b1;
        else if (wr(`RSOC_IX_HTF)) htf_q <= wb[`RSOC_B_HT];
    end
    // ----------------------------------------
    // Shared open-drain pin
    // ----------------------------------------
    logic irqCfg, irqAct;
    assign irqCfg = osc_fail_irq_en_q | alm1_q[`RSOC_B_TOP] | (|wdog_q);
    // fail irq released only via enable or flag
    assign irqAct = (osc_fail_irq_en_q & oscFail_q) | (alm1_q[`RSOC_B_TOP] & alarm1Hit)
        | ((|wdog_q) & wdogExpired) | (tctl_q[`RSOC_B_TIE] & cdFlag_q);
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) sharedIrqOe <= 1'b0;
        else sharedIrqOe <= irqAct | (~irqCfg & ~ctrl_q[`RSOC_B_TOP]);
    end
    assign sharedIrqOut = 1'b0;
    // ----------------------------------------
    // Analog trim register
    // ----------------------------------------
    rsoc_trim_e trim_q;
    logic [16:0] trimCnt_q;
    rsoc_byte_t acal_q;
    logic trimSel;
    assign trimSel = sqw_q[`RSOC_B_OTP];
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            trim_q    <= TRIM_IDLE;
            trimCnt_q <= '0;
        end else begin
            unique case (trim_q)
                TRIM_IDLE: begin
                    trimCnt_q <= '0;
                    if (trimSel) trim_q <= TRIM_WAIT;
                end
                TRIM_WAIT: begin
                    trimCnt_q <= trimCnt_q + 17'h1;
                    if (!trimSel) trim_q <= TRIM_IDLE;
                    else if (trimCnt_q == 17'(TRIM_CYCLES - 1)) trim_q <= TRIM_DONE;
                end
                TRIM_DONE: if (!trimSel) trim_q <= TRIM_IDLE;
            endcase
        end
    end
    // trim copy, user writes only when deselected
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) acal_q <= '0;
        else if (trim_q == TRIM_WAIT && trimCnt_q == 17'(TRIM_CYCLES - 1))
            acal_q <= factoryTrim;
        else if (!trimSel && wr(`RSOC_IX_ACAL)) acal_q <= wb;
    end
    // ----------------------------------------
    // Read data
    // ----------------------------------------
    rsoc_byte_t rd;
    logic hit;
    always_comb begin
        rd  = '0;
        hit = 1'b1;
        unique case (idx)
            `RSOC_IX_HALT: rd = {oscHalt, 7'h00};
            `RSOC_IX_CENT: rd = {cent_q, 6'h00};
            `RSOC_IX_CTRL: rd = ctrl_q;
            `RSOC_IX_WDOG: rd = wdog_q;
            `RSOC_IX_ALM1: rd = alm1_q;
            `RSOC_IX_OSC_FAIL_IRQ_EN: rd = {osc_fail_irq_en_q, 7'h00};
            `RSOC_IX_HTF:  rd = {1'b0, htf_q, 6'h00};
            `RSOC_IX_RPT1: rd = rpt1_q;
            `RSOC_IX_ALM2: rd = alm2_q;
            `RSOC_IX_FLAG: rd = {3'h0, battLow_q, cdFlag_q, oscFail_q, 2'h0};
            `RSOC_IX_TVAL: rd = tval_q;
            `RSOC_IX_TCTL: rd = tctl_q;
            `RSOC_IX_ACAL: rd = acal_q;
            `RSOC_IX_SQW:  rd = sqw_q;
            default: hit = 1'b0;
        endcase
    end
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (apbAcc && !rdy_q) begin
            prdata  <= {24'h000000, rd};
            pslverr <= ~hit | (paddr[7] | (|paddr[1:0]));
        end
    end
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sq_supply_a: assert property (@(posedge clk) disable iff (!rstN)
        !vccS |=> !sqWavePin) else $error("square wave on battery");
    sq_enable_a: assert property (@(posedge clk) disable iff (!rstN)
        (!alm1_q[`RSOC_B_SQ_OUT_EN] || rate == `RSOC_RATE_OFF) |=> !sqWavePin) else $error("square wave while disabled");
    osc_set_a: assert property (@(posedge clk) disable iff (!rstN)
        oscStopped |=> oscFail_q) else $error("osc stop not flagged");
    osc_hold_a: assert property (@(posedge clk) disable iff (!rstN)
        oscFail_q && !(wr(`RSOC_IX_FLAG) && !wb[`RSOC_B_OF]) |=> oscFail_q) else $error("osc fail flag lost");
    osc_irq_a: assert property (@(posedge clk) disable iff (!rstN)
        osc_fail_irq_en_q && oscFail_q |=> sharedIrqOe) else $error("osc fail irq missing");
    pin_level_a: assert property (@(posedge clk) disable iff (!rstN)
        !irqCfg && !irqAct |=> sharedIrqOe == !$past(ctrl_q[`RSOC_B_TOP]))
        else $error("pin does not follow output bit");
    cd_readclr_a: assert property (@(posedge clk) disable iff (!rstN)
        rdDone && idx == `RSOC_IX_FLAG && !countdownDone |=> !cdFlag_q)
        else $error("countdown flag not cleared by read");
    cd_keep_a: assert property (@(posedge clk) disable iff (!rstN)
        cdFlag_q && !rdDone |=> cdFlag_q) else $error("countdown flag dropped");
    batt_hold_a: assert property (@(posedge clk) disable iff (!rstN)
        !battCheck |=> battLow_q == $past(battLow_q)) else $error("battery flag moved");
    cent_step_a: assert property (@(posedge clk) disable iff (!rstN)
        centuryTick |=> cent_q == $past(cent_q) + 2'h1) else $error("century step wrong");
    acal_user_a: assert property (@(posedge clk) disable iff (!rstN)
        !trimSel && wr(`RSOC_IX_ACAL) && trim_q != TRIM_WAIT |=> acal_q == $past(wb))
        else $error("calibration write lost");
    acal_ro_a: assert property (@(posedge clk) disable iff (!rstN)
        trim_q == TRIM_DONE && trimSel |=> $stable(acal_q)) else $error("trim register written");
endmodule
`default_nettype wire

// >>> rsoc_host_model.sv
// Purpose: APB host model for the RTC housekeeping block
// Assumes: one transfer at a time, slave may stretch the access phase
// Notes:   all signals change just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module rsoc_host_model (
    input  wire logic        clk,     // bus clock
    output logic [7:0]       paddr,   // byte address
    output logic             psel,    // select
    output logic             penable, // access phase
    output logic             pwrite,  // write
    output logic [31:0]      pwdata,  // write data
    output logic [3:0]       pstrb,   // byte lanes
    input  wire logic [31:0] prdata,  // read data
    input  wire logic        pready,  // ready
    input  wire logic        pslverr  // error
);
    initial begin
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
        pstrb = 4'hF;
    end
    // ----------------------------------------
    // One transfer, held until pready
    // ----------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic restart();
        logic [7:0] q;
        logic       e;
        xfer(1'b1, {1'b0, `RSOC_IX_HALT, 2'b00}, 8'h80, q, e);
        xfer(1'b1, {1'b0, `RSOC_IX_HALT, 2'b00}, 8'h00, q, e);
    endtask
endmodule
`default_nettype wire

// >>> tb_rtc_status_output_control.sv
// Purpose: self-checking bench of the RTC housekeeping block
// Assumes: oscillator stand-in runs at clk/16 to keep the run short
// Notes:   battery check tested at power-up only, 2 s period too long
`timescale 1ns/1ps
`include "rsoc_cfg.svh"
`default_nettype none
module tb_rtc_status_output_control;
    import rsoc_pkg::*;
    logic        clk = 1'b0;
    logic        resetN, vccOk, battLow, oscRun, cdDone, alarm1, wdog, centTick;
    logic        sqWave, irqOut, irqOe, leap, oscHalt, ftEn, runEn;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [3:0]  pstrb;
    logic [3:0]  oscDiv = 4'h0;
    logic [31:0] pwdata, prdata;
    logic [6:0]  year;
    int          nFail, nTests;
    rsoc_byte_t  q;
    logic        e;
    rsoc_status_ctrl #(.BATT_PERIOD_S(2), .TRIM_CYCLES(8)) rsoc_status_ctrl_i (
        .clk(clk), .reset_n(resetN), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .oscClkPin(oscDiv[3]), .vccOkPin(vccOk), .battLowPin(battLow),
        .oscRunPin(oscRun), .countdownDone(cdDone), .alarm1Hit(alarm1), .wdogExpired(wdog),
        .centuryTick(centTick), .yearBin(year), .factoryTrim(8'hC3), .sqWavePin(sqWave),
        .sharedIrqOut(irqOut), .sharedIrqOe(irqOe), .leapYear(leap), .oscHalt(oscHalt),
        .freqTestEn(ftEn), .countdownRunEn(runEn));
    rsoc_host_model rsoc_host_model_i (
        .clk(clk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    always #20 clk = ~clk;
    always @(posedge clk) begin
        oscDiv <= oscDiv + 4'h1;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        nTests++;
        if (g !== x) begin
            nFail++;
            $display("Error %0t: value %h expected %h", $time, g, x);
        end
    endtask
    task automatic wr(input rsoc_idx_t ix, input rsoc_byte_t d);
        rsoc_host_model_i.xfer(1'b1, {1'b0, ix, 2'b00}, d, q, e);
    endtask
    task automatic rc(input rsoc_idx_t ix, input rsoc_byte_t x);
        rsoc_host_model_i.xfer(1'b0, {1'b0, ix, 2'b00}, 8'h00, q, e);
        chk(q, x);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    // Cycles with the square wave high over a span
    task automatic hiCount(input int n, output int h);
        h = 0;
        repeat (n) begin
            @(posedge clk);
            if (sqWave !== 1'b0) h++;
        end
    endtask
    task automatic sqChk(input int r);
        int h, l, n, x;
        h = 0;
        l = 0;
        n = 0;
        x = (r == 1) ? 8 : (8 << r);
        wr(`RSOC_IX_SQW, {r[3:0], 4'h0});
        tick(8);
        while (sqWave !== 1'b0 && n < 3000) begin @(posedge clk); n++; end
        while (sqWave !== 1'b1 && n < 3000) begin @(posedge clk); n++; end
        while (sqWave === 1'b1 && n < 3000) begin @(posedge clk); n++; h++; end
        while (sqWave === 1'b0 && n < 3000) begin @(posedge clk); n++; l++; end
        if (r == 0) hiCount(300, h);
        chk(h[15:0], (r == 0) ? 16'h0000 : x[15:0]);
        if (r != 0) chk(l[15:0], x[15:0]);
    endtask
    task automatic conclude();
        $display("Counts: %0d compared, %0d mismatched", nTests, nFail);
        if (nFail == 0 && nTests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        nFail++;
        conclude();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        int h;
        resetN = 1'b0; vccOk = 1'b1; battLow = 1'b0; oscRun = 1'b1;
        cdDone = 1'b0; alarm1 = 1'b0; wdog = 1'b0; centTick = 1'b0; year = 7'h00;
        nFail = 0; nTests = 0;
        tick(20);
        resetN <= 1'b1;
        tick(6);
        rc(`RSOC_IX_CTRL, 8'h80); rc(`RSOC_IX_HALT, 8'h00); rc(`RSOC_IX_OSC_FAIL_IRQ_EN, 8'h00);
        rc(`RSOC_IX_ALM1, 8'h40); rc(`RSOC_IX_WDOG, 8'h00); rc(`RSOC_IX_CENT, 8'h00);
        rc(`RSOC_IX_TCTL, 8'h03); rc(`RSOC_IX_SQW, 8'h10); rc(`RSOC_IX_FLAG, 8'h04);
        rc(`RSOC_IX_HTF, 8'h40); rc(`RSOC_IX_RPT1, 8'h00); rc(`RSOC_IX_ALM2, 8'h00);
        rsoc_host_model_i.xfer(1'b0, 8'h80, 8'h00, q, e);
        chk({7'h0, e}, 8'h01);
        done("defaults");
        chk(irqOe, 1'b0);
        wr(`RSOC_IX_CTRL, 8'h00); tick(4);
        chk(irqOe, 1'b1); chk(irqOut, 1'b0);
        wr(`RSOC_IX_WDOG, 8'h01); tick(4);
        chk(irqOe, 1'b0);
        wr(`RSOC_IX_WDOG, 8'h00); wr(`RSOC_IX_CTRL, 8'h80); tick(4);
        chk(irqOe, 1'b0);
        done("output pin");
        wr(`RSOC_IX_OSC_FAIL_IRQ_EN, 8'h80); tick(4);
        chk(irqOe, 1'b1);
        rc(`RSOC_IX_FLAG, 8'h04); tick(4);
        chk(irqOe, 1'b1);
        wr(`RSOC_IX_FLAG, 8'h00); tick(4);
        chk(irqOe, 1'b0); rc(`RSOC_IX_FLAG, 8'h00);
        @(posedge clk); oscRun <= 1'b0; tick(4); oscRun <= 1'b1; tick(6);
        rc(`RSOC_IX_FLAG, 8'h04); chk(irqOe, 1'b1);
        wr(`RSOC_IX_FLAG, 8'h00); rsoc_host_model_i.restart();
        tick(1); chk(oscHalt, 1'b0); rc(`RSOC_IX_FLAG, 8'h04);
        wr(`RSOC_IX_FLAG, 8'h00); wr(`RSOC_IX_OSC_FAIL_IRQ_EN, 8'h00);
        done("oscillator fail");
        @(posedge clk); cdDone <= 1'b1; @(posedge clk); cdDone <= 1'b0;
        wr(`RSOC_IX_TVAL, 8'h55);
        rc(`RSOC_IX_FLAG, 8'h08);
        rc(`RSOC_IX_FLAG, 8'h00);
        done("countdown flag");
        for (int r = 0; r < 7; r++) sqChk(r);
        wr(`RSOC_IX_SQW, 8'h10); wr(`RSOC_IX_ALM1, 8'h00); tick(4); hiCount(64, h);
        chk(h[7:0], 8'h00);
        wr(`RSOC_IX_ALM1, 8'h40); tick(4); hiCount(64, h);
        chk(h[7:0], 8'h20);
        done("square wave");
        wr(`RSOC_IX_CTRL, 8'hC0); wr(`RSOC_IX_TCTL, 8'h83); wr(`RSOC_IX_HTF, 8'h00);
        chk(ftEn, 1'b1); chk(runEn, 1'b1);
        @(posedge clk); vccOk <= 1'b0; battLow <= 1'b1; tick(8); hiCount(64, h);
        chk(h[7:0], 8'h00);
        vccOk <= 1'b1; tick(8);
        rc(`RSOC_IX_CTRL, 8'h80); rc(`RSOC_IX_TCTL, 8'h03); rc(`RSOC_IX_HTF, 8'h40);
        rc(`RSOC_IX_ALM1, 8'h40); chk(ftEn, 1'b0);
        rc(`RSOC_IX_FLAG, 8'h10);
        @(posedge clk); vccOk <= 1'b0; battLow <= 1'b0; tick(8);
        rc(`RSOC_IX_FLAG, 8'h10);
        vccOk <= 1'b1; tick(8);
        rc(`RSOC_IX_FLAG, 8'h00);
        done("power and battery");
        for (int c = 0; c < 4; c++) begin
            rc(`RSOC_IX_CENT, {c[1:0], 6'h00});
            year <= 7'd0; tick(3); chk(leap, c == 0);
            year <= 7'd4; tick(3); chk(leap, 1'b1);
            year <= 7'd1; tick(3); chk(leap, 1'b0);
            centTick <= 1'b1; @(posedge clk); centTick <= 1'b0; tick(2);
        end
        rc(`RSOC_IX_CENT, 8'h00);
        done("century");
        wr(`RSOC_IX_ACAL, 8'h5A); rc(`RSOC_IX_ACAL, 8'h5A);
        wr(`RSOC_IX_SQW, 8'h18); rc(`RSOC_IX_ACAL, 8'h5A); tick(20);
        rc(`RSOC_IX_ACAL, 8'hC3); wr(`RSOC_IX_ACAL, 8'h11); rc(`RSOC_IX_ACAL, 8'hC3);
        wr(`RSOC_IX_SQW, 8'h10); wr(`RSOC_IX_ACAL, 8'h11); rc(`RSOC_IX_ACAL, 8'h11);
        done("trim");
        conclude();
    end
endmodule
`default_nettype wire
